/* hdl/seit_pkg.sv */
// Package for the serial EEPROM two-wire target.
// Assumes a 50 MHz system clock samples the bus pins.
package seit_pkg;

    // ****************************************************************
    // Addressing
    // ****************************************************************
    localparam logic [3:0]  TYPE_MAIN     = 4'ha;
    localparam logic [3:0]  TYPE_ID       = 4'hb;
    localparam int          BYTE_BITS     = 8;
    localparam logic [3:0]  BIT_LAST      = 4'h8;
    localparam int          PAGE_AW       = 6;
    localparam int          PAGE_ROW_W    = 9;
    localparam int          PAGE_BYTES    = 64;
    localparam logic [PAGE_AW:0] COPY_LAST = 7'h40;
    localparam int          MEM_AW        = 16;
    localparam int          MEM_DEPTH     = 32832;
    localparam logic [15:0] ID_BASE       = 16'h8000;
    localparam int          ID_SEL_BIT    = 2;
    localparam int          LOCK_DATA_BIT = 1;

    // ****************************************************************
    // Pin sampling
    // ****************************************************************
    localparam int          PIN_W         = 6;
    localparam logic [5:0]  PIN_RST       = 6'h03;
    localparam int          PIN_SCL       = 0;
    localparam int          PIN_SDA       = 1;
    localparam int          PIN_WP        = 2;
    localparam int          PIN_STRAP     = 3;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          PROG_TIME_NS  = 3000000;
    localparam int          PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int          PROG_CNT_W    = 18;

    // ****************************************************************
    // States
    // ****************************************************************
    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_DEV    = 7'h02,
        ST_ADDR_H = 7'h04,
        ST_ADDR_L = 7'h08,
        ST_DATA   = 7'h10,
        ST_IGNORE = 7'h20,
        ST_PROG   = 7'h40
    } seit_state_type;

endpackage

/* hdl/seit_mem.sv */
// Simple dual-port byte memory with registered read data.
// Assumes one write and one read per clock, same clock domain.
`timescale 1ns/10ps
module seit_mem #(
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [7:0]    rdata_o
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0] mem_q [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // Read data registered so the owner sees one cycle of latency
    always_ff @(posedge clk_i) begin
        rdata_o <= mem_q[raddr_i];
    end

endmodule

/* hdl/seit_target.sv */
// Two-wire target logic of a serial EEPROM: device select, word
// address, page buffering and the self-timed programming cycle.
// Assumes the pad ring resolves the open-drain data wire and pulls
// floating straps low; the bus pins are asynchronous to clk_i.
//
// Functional notes
// - Data changes only with clock low; high-clock changes are start/stop.
// - Data falling with clock high is start; it opens every command.
// - Data rising with clock high is stop; ends transfer, back to standby.
// - Bytes are eight bits; each received byte acknowledged low on ninth clock.
// - Bits taken on clock rise; data output changes on clock fall.
// - Data line is only pulled low or released, never driven high.
// - Standby at power-up and after stop once programming is done.
// - Device byte follows start; top four bits carry type code.
// - Next three bits compared against the three chip select straps.
// - Unconnected strap inputs read as logic zero.
// - Last device byte bit: one is read, zero is write.
// - Match is acknowledged; mismatch returns to standby, rest ignored.
// - Main array is 512 pages of 64 bytes, 15-bit word address.
// - Write protect high shields whole main array from writes.
// - Write acks address and data; stop launches the programming cycle.
// - Programming cycle for byte or page completes within 3 ms.
// - During programming all bus inputs ignored, no acknowledge.
// - Page write advances in-page index only, wrapping within 64 bytes.
// - Id page write uses type 1011b, select bit zero, low six bits index.
// - Locked id page: data bytes not acknowledged, page unchanged.
// - Polling device byte is acknowledged only after programming ends.
// - Word address comes as high byte then low byte.
// - Id byte write with select bit one and data bit 1 locks page.
`timescale 1ns/10ps
module seit_target #(
    parameter int PROG_CYCLES = seit_pkg::PROG_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       wp_i,
    input  wire logic [2:0] chip_select_straps_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    output logic            standby_o,
    output logic            busy_o,
    output logic            id_locked_o
);

    // ****************************************************************
    // Pin sampling
    // ****************************************************************
    logic [seit_pkg::PIN_W-1:0] pin_raw;
    logic [seit_pkg::PIN_W-1:0] s1_q;
    logic [seit_pkg::PIN_W-1:0] s2_q;
    logic [seit_pkg::PIN_W-1:0] s3_q;
    logic [seit_pkg::PIN_W-1:0] filt_q;

    // Straps rely on the pad pull-down when left open
    assign pin_raw = {chip_select_straps_i, wp_i, sda_i, scl_i};

    // A level counts once stages two and three agree; glitch filter
    for (genvar g = 0; g < seit_pkg::PIN_W; g++) begin : g_sync
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                s1_q[g]   <= seit_pkg::PIN_RST[g];
                s2_q[g]   <= seit_pkg::PIN_RST[g];
                s3_q[g]   <= seit_pkg::PIN_RST[g];
                filt_q[g] <= seit_pkg::PIN_RST[g];
            end else begin
                s1_q[g] <= pin_raw[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                if (s2_q[g] == s3_q[g]) begin
                    filt_q[g] <= s3_q[g];
                end
            end
        end
    end

    logic       scl_f;
    logic       sda_f;
    logic       wp_f;
    logic [2:0] straps_f;
    logic       scl_prev_q;
    logic       sda_prev_q;

    assign scl_f    = filt_q[seit_pkg::PIN_SCL];
    assign sda_f    = filt_q[seit_pkg::PIN_SDA];
    assign wp_f     = filt_q[seit_pkg::PIN_WP];
    assign straps_f = filt_q[seit_pkg::PIN_STRAP +: 3];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_f;
            sda_prev_q <= sda_f;
        end
    end

    // ****************************************************************
    // Bus events
    // ****************************************************************
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    assign scl_rise = scl_f && !scl_prev_q;
    assign scl_fall = !scl_f && scl_prev_q;
    // Data edges with the clock high are framing, never data
    assign start_ev = scl_f && scl_prev_q && sda_prev_q && !sda_f;
    assign stop_ev  = scl_f && scl_prev_q && !sda_prev_q && sda_f;

    // ****************************************************************
    // Shift register and bit count
    // ****************************************************************
    seit_pkg::seit_state_type state_q;
    logic [3:0]  bit_cnt_q;
    logic [7:0]  shift_q;
    logic        ack_phase_q;
    logic        counting;
    logic        byte_done;
    logic        ack_end;
    logic        in_prog;

    assign in_prog  = (state_q == seit_pkg::ST_PROG);
    assign counting = (state_q == seit_pkg::ST_DEV)
                   || (state_q == seit_pkg::ST_ADDR_H)
                   || (state_q == seit_pkg::ST_ADDR_L)
                   || (state_q == seit_pkg::ST_DATA);
    assign byte_done = counting && scl_fall && !ack_phase_q
                    && (bit_cnt_q == seit_pkg::BIT_LAST);
    assign ack_end   = scl_fall && ack_phase_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
        end else if ((start_ev && !in_prog) || ack_end) begin
            bit_cnt_q <= 4'h0;
        end else if (counting && scl_rise
                     && bit_cnt_q != seit_pkg::BIT_LAST) begin
            shift_q   <= {shift_q[6:0], sda_f};
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // ****************************************************************
    // Acknowledge decision
    // ****************************************************************
    logic id_q;
    logic locked_q;
    logic lock_sel_q;
    logic dev_match;
    logic ack_now;
    logic buf_we;

    assign dev_match = (shift_q[7:4] == seit_pkg::TYPE_MAIN
                        || shift_q[7:4] == seit_pkg::TYPE_ID)
                    && (shift_q[3:1] == straps_f);

    always_comb begin
        case (state_q)
            seit_pkg::ST_DEV:    ack_now = dev_match;
            seit_pkg::ST_ADDR_H: ack_now = 1'b1;
            seit_pkg::ST_ADDR_L: ack_now = 1'b1;
            // Protected main array still acks; only programming is held
            seit_pkg::ST_DATA:   ack_now = !(id_q && locked_q
                                             && !lock_sel_q);
            default:             ack_now = 1'b0;
        endcase
    end

    // Open drain: only ever pull low or release
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_phase_q <= 1'b0;
            sda_oe_n_o  <= 1'b1;
            sda_o       <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            if ((start_ev || stop_ev) && !in_prog) begin
                ack_phase_q <= 1'b0;
                sda_oe_n_o  <= 1'b1;
            end else if (byte_done) begin
                ack_phase_q <= 1'b1;
                sda_oe_n_o  <= !ack_now;
            end else if (ack_end) begin
                ack_phase_q <= 1'b0;
                sda_oe_n_o  <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Main state machine
    // ****************************************************************
    localparam int PAGE_CW = seit_pkg::PROG_CNT_W;
    logic [PAGE_CW-1:0] prog_cnt_q;
    logic [seit_pkg::PAGE_BYTES-1:0] valid_q;
    logic        lock_req_q;
    logic        prog_go;
    logic        prog_last;

    // Protect pin shields the main array only
    assign prog_go   = (state_q == seit_pkg::ST_DATA)
                    && ((|valid_q) || lock_req_q)
                    && (id_q || !wp_f);
    assign prog_last = in_prog
                    && (prog_cnt_q == PAGE_CW'(PROG_CYCLES - 1));

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= seit_pkg::ST_IDLE;
        end else if (in_prog) begin
            // Bus ignored until the cell write finishes
            if (prog_last) begin
                state_q <= seit_pkg::ST_IDLE;
            end
        end else if (start_ev) begin
            state_q <= seit_pkg::ST_DEV;
        end else if (stop_ev) begin
            state_q <= prog_go ? seit_pkg::ST_PROG
                               : seit_pkg::ST_IDLE;
        end else if (byte_done) begin
            case (state_q)
                seit_pkg::ST_DEV: begin
                    if (!dev_match) begin
                        state_q <= seit_pkg::ST_IDLE;
                    end else if (shift_q[0]) begin
                        state_q <= seit_pkg::ST_IGNORE;
                    end else begin
                        state_q <= seit_pkg::ST_ADDR_H;
                    end
                end
                seit_pkg::ST_ADDR_H: state_q <= seit_pkg::ST_ADDR_L;
                seit_pkg::ST_ADDR_L: state_q <= seit_pkg::ST_DATA;
                default:             state_q <= state_q;
            endcase
        end
    end

    // ****************************************************************
    // Address capture and page buffer
    // ****************************************************************
    logic [7:0]                     addr_hi_q;
    logic [seit_pkg::PAGE_ROW_W-1:0] page_q;
    logic [seit_pkg::PAGE_AW-1:0]   idx_q;

    assign buf_we = byte_done && (state_q == seit_pkg::ST_DATA)
                 && !lock_sel_q && ack_now;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            id_q       <= 1'b0;
            addr_hi_q  <= 8'h00;
            page_q     <= '0;
            idx_q      <= '0;
            lock_sel_q <= 1'b0;
        end else if (byte_done) begin
            case (state_q)
                seit_pkg::ST_DEV:
                    id_q <= (shift_q[7:4] == seit_pkg::TYPE_ID);
                seit_pkg::ST_ADDR_H:
                    addr_hi_q <= shift_q;
                seit_pkg::ST_ADDR_L: begin
                    // High byte top bit dropped: 15-bit space
                    page_q     <= {addr_hi_q[6:0], shift_q[7:6]};
                    idx_q      <= shift_q[5:0];
                    lock_sel_q <= id_q
                               && addr_hi_q[seit_pkg::ID_SEL_BIT];
                end
                default: begin
                    if (buf_we) begin
                        idx_q <= idx_q + 6'h01;
                    end
                end
            endcase
        end
    end

    // Valid mask marks which page slots hold new bytes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            valid_q    <= '0;
            lock_req_q <= 1'b0;
        end else if ((start_ev && !in_prog) || prog_last) begin
            valid_q    <= '0;
            lock_req_q <= 1'b0;
        end else if (byte_done && state_q == seit_pkg::ST_DATA) begin
            if (buf_we) begin
                valid_q[idx_q] <= 1'b1;
            end
            if (lock_sel_q && shift_q[seit_pkg::LOCK_DATA_BIT]) begin
                lock_req_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Programming cycle
    // ****************************************************************
    logic [seit_pkg::PAGE_AW-1:0] cp_idx;
    logic        in_copy;
    logic        mem_we;
    logic [15:0] mem_addr;
    logic [7:0]  buf_rdata;

    assign cp_idx  = seit_pkg::PAGE_AW'(prog_cnt_q - PAGE_CW'(1));
    assign in_copy = in_prog && prog_cnt_q != '0
                  && prog_cnt_q <= PAGE_CW'(seit_pkg::COPY_LAST);
    assign mem_we  = in_copy && valid_q[cp_idx];
    assign mem_addr = id_q ? (seit_pkg::ID_BASE | 16'(cp_idx))
                           : {1'b0, page_q, cp_idx};

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prog_cnt_q <= '0;
        end else if (in_prog && !prog_last) begin
            prog_cnt_q <= prog_cnt_q + PAGE_CW'(1);
        end else begin
            prog_cnt_q <= '0;
        end
    end

    // Lock kept in a flop here; nonvolatile on silicon
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            locked_q <= 1'b0;
        end else if (prog_last && lock_req_q) begin
            locked_q <= 1'b1;
        end
    end

    seit_mem #(.DEPTH(seit_pkg::PAGE_BYTES), .AW(seit_pkg::PAGE_AW))
    u_page_buf (
        .clk_i   (clk_i),
        .we_i    (buf_we),
        .waddr_i (idx_q),
        .wdata_i (shift_q),
        .raddr_i (prog_cnt_q[seit_pkg::PAGE_AW-1:0]),
        .rdata_o (buf_rdata)
    );

    seit_mem #(.DEPTH(seit_pkg::MEM_DEPTH), .AW(seit_pkg::MEM_AW))
    u_array (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .waddr_i (mem_addr),
        .wdata_i (buf_rdata),
        .raddr_i (mem_addr),
        .rdata_o ()
    );

    // ****************************************************************
    // Status outputs
    // ****************************************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            standby_o   <= 1'b1;
            busy_o      <= 1'b0;
            id_locked_o <= 1'b0;
        end else begin
            standby_o   <= (state_q == seit_pkg::ST_IDLE);
            busy_o      <= in_prog;
            id_locked_o <= locked_q;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    oe_on_low_a: assert property ($changed(sda_oe_n_o) |-> !scl_f)
        else $error("data output changed while clock high");
    no_ack_prog_a: assert property (in_prog |=> sda_oe_n_o)
        else $error("data line pulled during programming");
    start_sel_a: assert property (start_ev && !in_prog |=>
        state_q == seit_pkg::ST_DEV && bit_cnt_q == 4'h0)
        else $error("start did not open device select");
    prog_deaf_a: assert property (in_prog && start_ev |=> in_prog)
        else $error("start accepted while programming");
    dev_ack_a: assert property (byte_done && state_q == seit_pkg::ST_DEV
        |=> sda_oe_n_o == !dev_match)
        else $error("device select acknowledge wrong");
    wp_hold_a: assert property (stop_ev && wp_f && !id_q && !in_prog
        |=> !in_prog)
        else $error("protected array started programming");
    wrap_a: assert property (buf_we |=> idx_q == $past(idx_q) + 6'h01)
        else $error("page index did not advance");
    lock_nack_a: assert property (byte_done && state_q == seit_pkg::ST_DATA
        && id_q && locked_q && !lock_sel_q |=> sda_oe_n_o)
        else $error("locked id page data acknowledged");
    prog_len_a: assert property (in_prog |->
        prog_cnt_q < PAGE_CW'(PROG_CYCLES))
        else $error("programming ran past its time");
    ack_ninth_a: assert property (byte_done && ack_now
        |=> !sda_oe_n_o ##1 !sda_oe_n_o)
        else $error("acknowledge not held into ninth clock");

    write_cv: cover property (stop_ev && prog_go && !in_prog);
    poll_cv: cover property (in_prog && start_ev);
    mismatch_cv: cover property (byte_done && state_q == seit_pkg::ST_DEV
        && !dev_match);
    lock_cv: cover property ($rose(locked_q));

endmodule

/* verification/seit_ctl_model.sv */
// Two-wire bus controller model that drives the EEPROM target.
// Assumes a pull-up on the data wire, resolved in the bench top.
`timescale 1ns/10ps
module seit_ctl_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // ****************************************************************
    // Bus phases, quarter period of 2 clk, 160 ns clock period
    // ****************************************************************
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic start;
        wt(2);
        sda_low_o = 1'b0;
        wt(2);
        scl_o = 1'b1;
        wt(4);
        sda_low_o = 1'b1;
        wt(4);
        scl_o = 1'b0;
    endtask
    task automatic stop;
        wt(2);
        sda_low_o = 1'b1;
        wt(2);
        scl_o = 1'b1;
        wt(4);
        sda_low_o = 1'b0;
        wt(4);
    endtask
    // Data moves only while the clock is low
    task automatic bit_x(input logic b, output logic r);
        wt(2);
        sda_low_o = ~b;
        wt(2);
        scl_o = 1'b1;
        wt(4);
        r = sda_i;
        scl_o = 1'b0;
    endtask
    // Extra low time before and after the ack bit: the target's filtered
    // pull and release lag the pin by about five clocks, so neither may
    // land while the clock is already high again
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        wt(4);
        bit_x(1'b1, r);
        ack = ~r;
        wt(4);
    endtask
    task automatic recover;
        logic r;
        repeat (9) bit_x(1'b1, r);
        start();
        stop();
    endtask
endmodule

/* verification/tb.sv */
// Self-checking bench for the serial EEPROM two-wire target.
// Assumes the controller model and a shortened programming time.
`timescale 1ns/10ps
module tb;
    logic       clk_i = 1'b0;
    logic       arst_n_i = 1'b0;
    logic       wp_i = 1'b0;
    logic [2:0] straps = 3'h5;
    logic       scl, sda_low, sda_o, sda_oe_n, standby, busy, locked;
    wire        sda_w;
    logic       a;
    int         mismatches = 0;
    int         comparisons = 0;
    always #10 clk_i = ~clk_i;
    // Pull-up wire: either party may only pull low
    assign sda_w = (sda_low || (!sda_oe_n && !sda_o)) ? 1'b0 : 1'b1;
    seit_ctl_model ctl (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
                        .sda_low_o(sda_low));
    seit_target #(.PROG_CYCLES(200)) DUT (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda_w),
        .wp_i(wp_i), .chip_select_straps_i(straps), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n), .standby_o(standby), .busy_o(busy),
        .id_locked_o(locked));
    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] dev, hi, lo, d0, input int n,
                      input logic dack);
        ctl.start();
        ctl.tx(dev, a);
        chk("dev ack", a, 1);
        ctl.tx(hi, a);
        chk("hi ack", a, 1);
        ctl.tx(lo, a);
        chk("lo ack", a, 1);
        for (int i = 0; i < n; i++) begin
            ctl.tx(d0 + 8'(i), a);
            chk("data ack", a, dack);
        end
        ctl.stop();
    endtask
    // Bounded waits: a hang is reported, not waited out
    task automatic prog(input logic exp);
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        chk("busy", busy, exp);
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        if (n == 400) begin
            chk("timeout", 1, 0);
            wrap_up();
        end
        chk("standby", standby, 1);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_byte_poll;
        wr(8'haa, 8'h92, 8'h34, 8'h5c, 1, 1);
        ctl.start();
        ctl.tx(8'haa, a);
        chk("poll busy", a, 0);
        ctl.stop();
        prog(1);
        chk("byte", DUT.u_array.mem_q[16'h1234], 8'h5c);
        ctl.start();
        ctl.tx(8'haa, a);
        chk("poll done", a, 1);
        ctl.stop();
    endtask
    task automatic t_select;
        ctl.start();
        ctl.tx(8'ha2, a);
        chk("strap miss", a, 0);
        ctl.tx(8'h00, a);
        chk("ignored", a, 0);
        ctl.stop();
        chk("standby", standby, 1);
        // Reads are not built: the select is acked, the rest ignored
        ctl.start();
        ctl.tx(8'hab, a);
        chk("read sel", a, 1);
        ctl.tx(8'h00, a);
        chk("read rest", a, 0);
        ctl.stop();
        // Standby follows the filtered stop by a few clocks
        repeat (4) @(negedge clk_i);
        chk("read stop", standby, 1);
    endtask
    task automatic t_page_wrap;
        wr(8'haa, 8'h01, 8'h3e, 8'h10, 3, 1);
        prog(1);
        chk("pg 3e", DUT.u_array.mem_q[16'h013e], 8'h10);
        chk("pg 3f", DUT.u_array.mem_q[16'h013f], 8'h11);
        chk("pg 00", DUT.u_array.mem_q[16'h0100], 8'h12);
    endtask
    task automatic t_protect;
        wp_i = 1'b1;
        wr(8'haa, 8'h00, 8'h05, 8'h77, 1, 1);
        prog(0);
        wp_i = 1'b0;
    endtask
    task automatic t_id_page;
        wr(8'hba, 8'h00, 8'h07, 8'h66, 1, 1);
        prog(1);
        chk("id byte", DUT.u_array.mem_q[16'h8007], 8'h66);
        wr(8'hba, 8'h04, 8'h00, 8'h02, 1, 1);
        prog(1);
        chk("locked", locked, 1);
        wr(8'hba, 8'h00, 8'h07, 8'h33, 1, 0);
        prog(0);
        chk("id kept", DUT.u_array.mem_q[16'h8007], 8'h66);
        chk("pull value", sda_o, 0);
    endtask
    initial begin
        repeat (12) @(negedge clk_i);
        arst_n_i = 1'b1;
        chk("ack idle", sda_oe_n, 1);
        chk("standby", standby, 1);
        repeat (4) @(negedge clk_i);
        ctl.recover();
        t_byte_poll();
        t_select();
        t_page_wrap();
        t_protect();
        t_id_page();
        wrap_up();
    end
endmodule
